/* hw/monitor_config_four_bank.sv */
// lockable configuration bank for pin role, overtemp output and attenuators
module monitor_config_four_bank #(
    parameter int n_chan = 3,
    parameter int n_fan = 4
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // thermal inputs from the measurement logic, same clock
    input wire logic [n_chan*8-1:0] chan_temp,
    input wire logic [n_chan*8-1:0] chan_limit,
    input wire logic [n_fan*8-1:0] max_speed,
    input wire logic [n_fan*8-1:0] normal_duty,
    // shared pin and its role-specific sources
    input wire logic alert_level,
    input wire logic gpio_out_level,
    input wire logic gpio_out_enable,
    input wire logic shared_pin_in,
    // controlled functions
    output logic [1:0] shared_pin_role_select,
    output logic shared_pin_out,
    output logic shared_pin_oe,
    output logic fan_four_speed_input,
    output logic overtemp_signal,
    output logic [3:0] bypass_divider_rails,
    output logic [n_fan*8-1:0] fan_duty,
    output logic signed_range_select,
    output logic cfg_locked
);

    monitor_cfg_pkg::pin_cfg_t cfg_r, cfg_nxt;
    logic lock_r, lock_nxt;
    logic range_r, range_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic pin_s1_r, pin_s2_r;
    logic pin_out_r, pin_out_nxt;
    logic pin_oe_r, pin_oe_nxt;
    logic tach_r, tach_nxt;
    logic overtemp_r, overtemp_nxt;
    logic [n_fan*8-1:0] duty_r, duty_nxt;
    logic [n_chan-1:0] chan_over;
    logic any_over;
    logic setup;
    logic [7:0] word_idx;

    function automatic logic addr_known(input logic [7:0] idx);
        addr_known = (idx == monitor_cfg_pkg::pin_role_cfg_idx)
                  || (idx == monitor_cfg_pkg::factory_test_one_idx)
                  || (idx == monitor_cfg_pkg::factory_test_two_idx)
                  || (idx == monitor_cfg_pkg::lock_ctrl_idx);
    endfunction : addr_known

    genvar gi;
    generate
        for (gi = 0; gi < n_chan; gi++)
        begin : g_chan
            overtemp_channel_gate u_gate (
                .temp(chan_temp[gi*8 +: 8]),
                .limit(chan_limit[gi*8 +: 8]),
                .signed_range(range_r),
                .over(chan_over[gi])
            );
        end
    endgenerate

    assign any_over = |chan_over;
    assign setup = psel && !penable;
    assign word_idx = paddr[9:2];

    // bus: answer one cycle after setup, so every access has one wait-free access phase
    always_comb
    begin
        cfg_nxt = cfg_r;
        lock_nxt = lock_r;
        range_nxt = range_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        if (setup)
        begin
            pready_nxt = 1'b1;
            pslverr_nxt = !addr_known(word_idx) || paddr[31:10] != 22'h0 || paddr[1:0] != 2'h0;
            prdata_nxt = 32'h0;
            if (!pwrite)
            begin
                case (word_idx)
                    monitor_cfg_pkg::pin_role_cfg_idx: prdata_nxt[7:0] = cfg_r;
                    monitor_cfg_pkg::factory_test_one_idx,
                    monitor_cfg_pkg::factory_test_two_idx:
                        prdata_nxt[7:0] = monitor_cfg_pkg::factory_test_reset;
                    monitor_cfg_pkg::lock_ctrl_idx:
                    begin
                        prdata_nxt[monitor_cfg_pkg::lock_bit] = lock_r;
                        prdata_nxt[monitor_cfg_pkg::range_bit] = range_r;
                    end
                    default: prdata_nxt = 32'h0;
                endcase
            end
        end
        // writes land on the completing access edge
        if (psel && penable && pready_r && pwrite && pstrb[0] && !pslverr_r)
        begin
            case (word_idx)
                monitor_cfg_pkg::pin_role_cfg_idx:
                    if (!lock_r)
                        cfg_nxt = pwdata[7:0];
                monitor_cfg_pkg::lock_ctrl_idx:
                begin
                    // lock is sticky until reset
                    lock_nxt = lock_r | pwdata[monitor_cfg_pkg::lock_bit];
                    range_nxt = pwdata[monitor_cfg_pkg::range_bit];
                end
                default: cfg_nxt = cfg_r;
            endcase
        end
    end

    // pin, tach, overtemp and fan outputs follow the stored fields one cycle later
    always_comb
    begin
        pin_out_nxt = 1'b0;
        pin_oe_nxt = 1'b0;
        tach_nxt = 1'b0;
        overtemp_nxt = 1'b0;
        duty_nxt = normal_duty;
        case (cfg_r.role)
            monitor_cfg_pkg::role_fan_four_tach: tach_nxt = pin_s2_r;
            monitor_cfg_pkg::role_overtemp:
            begin
                // open drain, active low: pull down while overtemp
                overtemp_nxt = any_over && !cfg_r.inhibit;
                pin_oe_nxt = overtemp_nxt;
            end
            monitor_cfg_pkg::role_alert: pin_oe_nxt = alert_level;
            monitor_cfg_pkg::role_gpio:
            begin
                pin_out_nxt = gpio_out_level;
                pin_oe_nxt = gpio_out_enable;
            end
            default: pin_oe_nxt = 1'b0;
        endcase
        // fans react to overtemp even if the pin output is inhibited
        if (any_over)
            duty_nxt = cfg_r.ceiling_sel ? max_speed
                                         : {n_fan{monitor_cfg_pkg::full_speed_duty}};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r <= monitor_cfg_pkg::pin_role_cfg_reset;
            lock_r <= monitor_cfg_pkg::lock_ctrl_reset[monitor_cfg_pkg::lock_bit];
            range_r <= monitor_cfg_pkg::lock_ctrl_reset[monitor_cfg_pkg::range_bit];
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
            tach_r <= 1'b0;
            overtemp_r <= 1'b0;
            duty_r <= '0;
        end
        else if (clk_en)
        begin
            cfg_r <= cfg_nxt;
            lock_r <= lock_nxt;
            range_r <= range_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            pin_s1_r <= shared_pin_in;
            pin_s2_r <= pin_s1_r;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            tach_r <= tach_nxt;
            overtemp_r <= overtemp_nxt;
            duty_r <= duty_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign shared_pin_role_select = cfg_r.role;
    assign shared_pin_out = pin_out_r;
    assign shared_pin_oe = pin_oe_r;
    assign fan_four_speed_input = tach_r;
    assign overtemp_signal = overtemp_r;
    assign bypass_divider_rails = cfg_r.bypass;
    assign fan_duty = duty_r;
    assign signed_range_select = range_r;
    assign cfg_locked = lock_r;

endmodule : monitor_config_four_bank

/* common/monitor_cfg_pkg.sv */
// shared constants and carriers for the monitor configuration bank
package monitor_cfg_pkg;

    // register word offsets; printed offsets are not multiples of four,
    // so they are indices and the byte address is four times the index
    localparam logic [7:0] pin_role_cfg_idx = 8'h7d;
    localparam logic [7:0] factory_test_one_idx = 8'h7e;
    localparam logic [7:0] factory_test_two_idx = 8'h7f;
    // own choice: lock and range-select bits live in a small control word
    localparam logic [7:0] lock_ctrl_idx = 8'h80;

    localparam logic [7:0] pin_role_cfg_reset = 8'h00;
    localparam logic [7:0] factory_test_reset = 8'h00;
    localparam logic [1:0] lock_ctrl_reset = 2'h0;

    // field positions of the configuration word
    localparam int role_lsb = 0;
    localparam int inhibit_bit = 2;
    localparam int ceiling_bit = 3;
    localparam int bypass_lsb = 4;
    // field positions of the control word
    localparam int lock_bit = 0;
    localparam int range_bit = 1;

    // shared pin role codes
    localparam logic [1:0] role_fan_four_tach = 2'h0;
    localparam logic [1:0] role_overtemp = 2'h1;
    localparam logic [1:0] role_alert = 2'h2;
    localparam logic [1:0] role_gpio = 2'h3;

    // limit codes that switch a channel's overtemp output off
    localparam logic [7:0] limit_off_offset64 = 8'h00;
    localparam logic [7:0] limit_off_twos = 8'h80;

    localparam logic [7:0] full_speed_duty = 8'hff;

    typedef struct packed {
        logic [7:0] paddr_word;
        logic [31:0] pwdata;
        logic pwrite;
        logic psel;
        logic penable;
    } apb_req_t;

    typedef struct packed {
        logic [3:0] bypass;
        logic ceiling_sel;
        logic inhibit;
        logic [1:0] role;
    } pin_cfg_t;

endpackage : monitor_cfg_pkg

/* hw/overtemp_channel_gate.sv */
// per-channel overtemp decision, honouring the disable limit code
module overtemp_channel_gate (
    // channel data
    input wire logic [7:0] temp,
    input wire logic [7:0] limit,
    input wire logic signed_range,
    // result
    output logic over
);

    logic off_code;
    logic exceeded;

    always_comb
    begin
        // in offset-64 the code is offset by 64; signed compare otherwise
        off_code = signed_range ? (limit == monitor_cfg_pkg::limit_off_twos)
                                : (limit == monitor_cfg_pkg::limit_off_offset64);
        exceeded = signed_range ? ($signed(temp) > $signed(limit))
                                : (temp > limit);
        over = exceeded && !off_code;
    end

endmodule : overtemp_channel_gate

/* sim/monitor_config_four_bank_monitor.sv */
// port-level assertions for the configuration bank
module monitor_config_four_bank_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // controlled functions
    input wire logic [1:0] shared_pin_role_select,
    input wire logic shared_pin_oe,
    input wire logic [3:0] bypass_divider_rails,
    input wire logic cfg_locked
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] cfg_a = {22'h0, monitor_cfg_pkg::pin_role_cfg_idx, 2'h0};
    logic cfg_wr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign cfg_wr = psel && penable && pready && pwrite && paddr == cfg_a && pstrb[0];
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    role_write_a: assert property (cfg_wr && !cfg_locked |-> ##2
        shared_pin_role_select == $past(pwdata[1:0], 2)) else $error("role not written");
    bypass_write_a: assert property (cfg_wr && !cfg_locked |-> ##2
        bypass_divider_rails == $past(pwdata[7:4], 2)) else $error("bypass not written");
    locked_hold_a: assert property (cfg_locked [*3] |=> $stable(shared_pin_role_select)
        && $stable(bypass_divider_rails)) else $error("locked config changed");
    reset_zero_a: assert property ($rose(presetn) |->
        shared_pin_role_select == 2'h0 && bypass_divider_rails == 4'h0) else $error("not zero");
    test_read_zero_a: assert property (pready && !pwrite && (paddr == 32'h1f8 ||
        paddr == 32'h1fc) |-> prdata == 32'h0) else $error("test register not zero");
    tach_no_drive_a: assert property (shared_pin_role_select == 2'h0 &&
        $past(shared_pin_role_select) == 2'h0 |-> !shared_pin_oe) else $error("tach pin driven");
    misaligned_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned not refused");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule : monitor_config_four_bank_monitor

/* sim/monitor_config_four_bank_tb.sv */
// self-checking bench for the configuration bank
module monitor_config_four_bank_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] cfg_a = {22'h0, monitor_cfg_pkg::pin_role_cfg_idx, 2'h0};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, d;
    logic [23:0] chan_temp, chan_limit;
    logic [31:0] max_speed, normal_duty;
    logic alert_level, gpio_out_level, gpio_out_enable, shared_pin_in;
    logic [32:0] q[$];
    logic [32:0] e;
    int seed = 32'ha43093c5;
    int n_mismatch = 0;
    int tests_run = 0;
    localparam logic [31:0] full_duty = {4{monitor_cfg_pkg::full_speed_duty}};
    logic ot, pin_oe, pin_out, tach, ranged, locked, wander, probe;
    logic [31:0] duty, ms, nd;
    // expected pin bundle: overtemp, oe, out, tach, range, lock, duty
    logic [37:0] oq[$];
    logic [37:0] o;
    monitor_config_four_bank monitor_config_four_bank_i (.pclk(pclk), .presetn(presetn),
        .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_temp(chan_temp), .chan_limit(chan_limit), .max_speed(max_speed),
        .normal_duty(normal_duty), .alert_level(alert_level), .gpio_out_level(gpio_out_level),
        .gpio_out_enable(gpio_out_enable), .shared_pin_in(shared_pin_in),
        .shared_pin_role_select(), .shared_pin_out(pin_out), .shared_pin_oe(pin_oe),
        .fan_four_speed_input(tach), .overtemp_signal(ot), .bypass_divider_rails(),
        .fan_duty(duty), .signed_range_select(ranged), .cfg_locked(locked));
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (x !== g)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task chk_pins(input logic [37:0] x);
        chk("overtemp_signal", {31'h0, x[37]}, {31'h0, ot});
        chk("shared_pin_oe", {31'h0, x[36]}, {31'h0, pin_oe});
        chk("shared_pin_out", {31'h0, x[35]}, {31'h0, pin_out});
        chk("fan_four_speed_input", {31'h0, x[34]}, {31'h0, tach});
        chk("signed_range_select", {31'h0, x[33]}, {31'h0, ranged});
        chk("cfg_locked", {31'h0, x[32]}, {31'h0, locked});
        chk("fan_duty", x[31:0], duty);
    endtask : chk_pins
    // pin outputs lag the inputs by up to three flops, so look on the fourth edge
    task settle(input logic [23:0] t, input logic [23:0] l, input logic [37:0] x);
        chan_temp <= t;
        chan_limit <= l;
        oq.push_back(x);
        repeat (3) @(posedge pclk);
        probe <= 1'b1;
        @(posedge pclk);
        probe <= 1'b0;
    endtask : settle
    task apb(input logic [31:0] a, input logic [31:0] w, input logic wr);
        psel <= 1'b1;
        paddr <= a;
        pwdata <= w;
        pwrite <= wr;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task rd(input logic [31:0] a, input logic [31:0] x, input logic err);
        q.push_back({err, x});
        apb(a, 32'h0, 1'b0);
    endtask : rd
    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // watcher: every read answer is matched against the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && pwrite === 1'b0 && q.size() > 0)
        begin
            e = q.pop_front();
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
            if (!e[32]) chk("prdata", e[31:0], prdata);
        end
        if (probe && oq.size() > 0)
        begin
            o = oq.pop_front();
            chk_pins(o);
        end
    end
    // thermal and pin inputs wander so the logic behind them is exercised
    always @(posedge pclk)
        if (wander)
        {chan_temp, chan_limit, max_speed, normal_duty, alert_level, gpio_out_level,
            gpio_out_enable, shared_pin_in} <= 116'({$random(seed), $random(seed),
            $random(seed), $random(seed)});
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial
    begin
        #20000;
        n_mismatch++;
        conclude();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {chan_temp, chan_limit, max_speed, normal_duty} = '0;
        {alert_level, gpio_out_level, gpio_out_enable, shared_pin_in} = '0;
        {wander, probe} = 2'b10;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(cfg_a, 32'h0, 1'b0);
        rd(32'h1f8, 32'h0, 1'b0);
        rd(32'h1fc, 32'h0, 1'b0);
        $display("reset values test done");
        for (int i = 0; i < 4; i++)
        begin
            d = $random(seed);
            d[1:0] = 2'(i);
            apb(cfg_a, d, 1'b1);
            rd(cfg_a, {24'h0, d[7:0]}, 1'b0);
        end
        $display("role and bypass test done");
        apb(32'h1f8, $random(seed), 1'b1);
        rd(32'h1f8, 32'h0, 1'b0);
        rd(32'h300, 32'h0, 1'b1);
        rd(cfg_a + 32'h1, 32'h0, 1'b1);
        $display("read-only and refusal test done");
        // stop the wander one edge early so it cannot overwrite the fixed values
        wander <= 1'b0;
        @(posedge pclk);
        ms = $random(seed);
        nd = $random(seed);
        {max_speed, normal_duty} <= {ms, nd};
        {alert_level, gpio_out_level, gpio_out_enable, shared_pin_in} <= 4'hf;
        apb(cfg_a, 32'h1, 1'b1);
        settle(24'h000090, 24'hffff80, {6'b110000, full_duty});
        settle(24'h000090, 24'hffff00, {6'b000000, nd});
        apb(cfg_a, 32'hd, 1'b1);
        settle(24'h000090, 24'hffff80, {6'b000000, ms});
        apb(32'h200, 32'h2, 1'b1);
        apb(cfg_a, 32'h1, 1'b1);
        settle(24'h000090, 24'h7f7f10, {6'b000010, nd});
        settle(24'h000020, 24'h7f7f80, {6'b000010, nd});
        settle(24'h000020, 24'h7f7f10, {6'b110010, full_duty});
        apb(32'h200, 32'h0, 1'b1);
        $display("overtemp and fan test done");
        apb(cfg_a, 32'h0, 1'b1);
        settle(24'h0, 24'hffffff, {6'b000100, nd});
        apb(cfg_a, 32'h2, 1'b1);
        settle(24'h0, 24'hffffff, {6'b010000, nd});
        apb(cfg_a, 32'h3, 1'b1);
        settle(24'h0, 24'hffffff, {6'b011000, nd});
        $display("pin role test done");
        apb(32'h200, 32'h1, 1'b1);
        apb(cfg_a, ~d, 1'b1);
        rd(cfg_a, 32'h3, 1'b0);
        settle(24'h0, 24'hffffff, {6'b011001, nd});
        $display("lock test done");
        repeat (4) @(posedge pclk);
        conclude();
    end
endmodule : monitor_config_four_bank_tb

bind monitor_config_four_bank monitor_config_four_bank_monitor monitor_config_four_bank_monitor_i (.*);
